// [verilog/adc_slot_ctrl.sv]
// Timer-triggered slot sequencer and motor trigger word of one converter unit.
// Assumes trigger pulse and converter done come from logic on CLK_I.
// Behaviour
// - timer five pulse starts timer slot sequence
// - twelve 8-bit slot bytes, four per word
// - only enabled timer slots are converted
// - slot result goes to same-index result register
// - raise completion interrupt when sequence finishes
// - 5-bit channel code selects input N
// - byte bit7 enable, bits4-0 channel, 6-5 zero
// - all slot fields reset to zero
// - motor word: four slots, enable, tag, channel
// - phase tag 00 none, 01 U, 10 V, 11 W
`default_nettype none
module adc_slot_ctrl
    import adc_slot_pkg::*;
#(
    parameter bit UNIT_B = 1'b0
)
(
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic HSEL_I,
    input wire logic [7:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic TIMER5_TRIGGER_PULSE_I,
    input wire logic CONV_DONE_I,
    output conv_req_s CONV_REQ_O,
    output logic [31:0] MOTOR_TRIGGER_PROGRAM_FIVE_O,
    output logic TIMER_CONVERSION_DONE_IRQ_O
);
    // ==========================================================
    // State
    logic [31:0] motor_word;
    logic [31:0] timer_word [TIMER_WORDS];
    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_mask;
    logic irq;
    logic [31:0] rdata;
    logic wr_pending;
    logic [7:0] wr_addr;
    seq_state_e state;
    logic [3:0] slot;
    conv_req_s req;
    logic [31:0] next_motor_word;
    logic [31:0] next_timer_word [TIMER_WORDS];
    logic [IRQ_BITS-1:0] next_irq_status;
    logic [IRQ_BITS-1:0] next_irq_mask;
    logic next_irq;
    logic [31:0] next_rdata;
    logic next_wr_pending;
    logic [7:0] next_wr_addr;
    seq_state_e next_state;
    logic [3:0] next_slot;
    conv_req_s next_req;
    logic addr_phase;
    logic [7:0] slot_byte;
    logic slot_enabled;
    logic seq_finish;
    logic overrun;

    // Byte of the slot under scan; word by slot[3:2], lane by slot[1:0]
    always_comb
    begin
        slot_byte = timer_word[slot[3:2]][{slot[1:0], 3'b000} +: 8];
        slot_enabled = slot_byte[SLOT_ENABLE_BIT];
    end

    // ==========================================================
    // Sequencer: scans slots 0..11, one conversion at a time
    always_comb
    begin
        next_state = state;
        next_slot = slot;
        next_req = req;
        next_req.start = 1'b0;
        seq_finish = 1'b0;
        overrun = 1'b0;
        unique case (state)
            SEQ_IDLE:
            begin
                if (TIMER5_TRIGGER_PULSE_I)
                begin
                    next_state = SEQ_SCAN;
                    next_slot = 4'h0;
                end
            end
            SEQ_SCAN:
            begin
                if (slot_enabled)
                begin
                    next_state = SEQ_START;
                end
                else if (slot == LAST_SLOT)
                begin
                    next_state = SEQ_IDLE;
                    seq_finish = 1'b1;
                end
                else
                begin
                    next_slot = slot + 4'h1;
                end
            end
            SEQ_START:
            begin
                // Reserved codes are passed on untouched
                next_req.start = 1'b1;
                next_req.channel = slot_byte[4:0];
                next_req.result_slot = slot;
                next_state = SEQ_WAIT;
            end
            SEQ_WAIT:
            begin
                if (CONV_DONE_I && slot == LAST_SLOT)
                begin
                    next_state = SEQ_IDLE;
                    seq_finish = 1'b1;
                end
                else if (CONV_DONE_I)
                begin
                    next_slot = slot + 4'h1;
                    next_state = SEQ_SCAN;
                end
            end
        endcase
        // A trigger during a running sequence is dropped, only flagged
        if (state != SEQ_IDLE && TIMER5_TRIGGER_PULSE_I)
        begin
            overrun = 1'b1;
        end
    end

    // ==========================================================
    // Bus slave: zero wait states, write data lands in the data phase
    always_comb
    begin
        addr_phase = HSEL_I && HTRANS_I[1] && HREADY_I;
        next_wr_pending = addr_phase && HWRITE_I;
        next_wr_addr = HADDR_I;
        next_motor_word = motor_word;
        next_timer_word = timer_word;
        next_irq_mask = irq_mask;
        if (wr_pending)
        begin
            unique case (wr_addr)
                MOTOR_FIVE_OFS: next_motor_word = HWDATA_I;
                TIMER_0_3_OFS: next_timer_word[0] = HWDATA_I & TIMER_WORD_MASK;
                TIMER_4_7_OFS: next_timer_word[1] = HWDATA_I & TIMER_WORD_MASK;
                TIMER_8_11_OFS:
                    next_timer_word[2] = HWDATA_I & TIMER_WORD_MASK;
                IRQ_MASK_OFS: next_irq_mask = HWDATA_I[IRQ_BITS-1:0];
                default: next_motor_word = motor_word;
            endcase
        end
        // Reads see a write still in its data phase: no stale read-back
        next_rdata = 32'h00000000;
        next_irq_status = irq_status;
        if (addr_phase && !HWRITE_I)
        begin
            unique case (HADDR_I)
                MOTOR_FIVE_OFS: next_rdata = next_motor_word;
                TIMER_0_3_OFS: next_rdata = next_timer_word[0];
                TIMER_4_7_OFS: next_rdata = next_timer_word[1];
                TIMER_8_11_OFS: next_rdata = next_timer_word[2];
                IRQ_STATUS_OFS:
                begin
                    next_rdata[IRQ_BITS-1:0] = irq_status;
                    next_irq_status = IRQ_RESET;
                end
                IRQ_MASK_OFS: next_rdata[IRQ_BITS-1:0] = next_irq_mask;
                SEQ_STATUS_OFS: next_rdata = {24'h000000, slot, 2'b00, state};
                default: next_rdata = 32'h00000000;
            endcase
        end
        // Set after clear so a same-cycle event is never lost
        if (seq_finish)
        begin
            next_irq_status[IRQ_DONE_BIT] = 1'b1;
        end
        if (overrun)
        begin
            next_irq_status[IRQ_OVERRUN_BIT] = 1'b1;
        end
        next_irq = |(next_irq_status & next_irq_mask);
    end

    // Registers only; every field starts at zero
    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            motor_word <= MOTOR_WORD_RESET;
            for (int w = 0; w < TIMER_WORDS; w++)
            begin
                timer_word[w] <= TIMER_WORD_RESET;
            end
            irq_status <= IRQ_RESET;
            irq_mask <= IRQ_RESET;
            irq <= 1'b0;
            rdata <= 32'h00000000;
            wr_pending <= 1'b0;
            wr_addr <= 8'h00;
            state <= SEQ_IDLE;
            slot <= 4'h0;
            req <= '0;
        end
        else
        begin
            motor_word <= next_motor_word;
            timer_word <= next_timer_word;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            irq <= next_irq;
            rdata <= next_rdata;
            wr_pending <= next_wr_pending;
            wr_addr <= next_wr_addr;
            state <= next_state;
            slot <= next_slot;
            req <= next_req;
        end
    end

    // ==========================================================
    // Outputs straight from flops, HREADYOUT_O and HRESP_O tied constant; tag field feeds the vector engine
    assign HRDATA_O = rdata;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;
    assign CONV_REQ_O = req;
    assign MOTOR_TRIGGER_PROGRAM_FIVE_O = motor_word;
    assign TIMER_CONVERSION_DONE_IRQ_O = irq;

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    // Highest legal channel code of this unit; only the cover reads it
    logic [4:0] max_channel;
    assign max_channel = UNIT_B ? UNIT_B_MAX_CHANNEL : UNIT_A_MAX_CHANNEL;

    trigger_start_a: assert property (
        state == SEQ_IDLE && TIMER5_TRIGGER_PULSE_I
        |=> state == SEQ_SCAN && slot == 4'h0)
        else $error("trigger did not start the scan");
    enabled_only_a: assert property (
        req.start |-> $past(slot_enabled, 1))
        else $error("disabled slot was converted");
    result_index_a: assert property (
        req.start |-> req.result_slot == $past(slot, 1))
        else $error("result slot differs from slot index");
    done_irq_a: assert property (
        state == SEQ_WAIT && CONV_DONE_I && slot == LAST_SLOT
        |=> irq_status[IRQ_DONE_BIT] ##0 state == SEQ_IDLE)
        else $error("completion not flagged");
    channel_pass_a: assert property (
        req.start |-> req.channel == $past(slot_byte[4:0], 1))
        else $error("channel code not passed through");
    reserved_zero_a: assert property (
        ((timer_word[0] | timer_word[1] | timer_word[2])
        & ~TIMER_WORD_MASK) == 32'h00000000)
        else $error("reserved slot bits not zero");
    reset_zero_a: assert property (@(posedge CLK_I) disable iff (1'b0)
        !NRST_I |=> motor_word == 32'h00000000
        && timer_word[0] == 32'h00000000 && slot == 4'h0)
        else $error("slot fields not zero after reset");
    ascending_a: assert property (
        state == SEQ_WAIT && CONV_DONE_I && slot != LAST_SLOT
        |=> slot == $past(slot, 1) + 4'h1 ##0 state == SEQ_SCAN)
        else $error("slots not scanned in ascending order");
    // The irq flop follows the same next values as status, no lag
    irq_level_a: assert property (
        $rose(irq_status[IRQ_DONE_BIT]) && irq_mask[IRQ_DONE_BIT]
        |-> TIMER_CONVERSION_DONE_IRQ_O)
        else $error("unmasked completion did not raise irq");
    skip_disabled_a: assert property (
        state == SEQ_SCAN && !slot_enabled |=> state != SEQ_START)
        else $error("disabled slot entered start");
    irq_follow_a: assert property (
        TIMER_CONVERSION_DONE_IRQ_O == |(irq_status & irq_mask))
        else $error("irq level differs from masked status");
    scan_end_a: assert property (
        state == SEQ_SCAN && slot == LAST_SLOT && !slot_enabled
        |=> irq_status[IRQ_DONE_BIT] && state == SEQ_IDLE)
        else $error("empty last slot did not finish");
    overrun_flag_a: assert property (
        overrun |=> irq_status[IRQ_OVERRUN_BIT])
        else $error("dropped trigger not flagged");

    full_scan_c: cover property (
        req.start && req.result_slot == LAST_SLOT ##[1:20] seq_finish);
    empty_scan_c: cover property (
        state == SEQ_SCAN && slot == LAST_SLOT && !slot_enabled);
    overrun_c: cover property (overrun);
    reserved_code_c: cover property (req.start && req.channel > max_channel);
endmodule : adc_slot_ctrl
`default_nettype wire

// [verilog/adc_slot_pkg.sv]
// Constants, register map and carrier types for the converter slot block.
// Assumes one 100 MHz system clock shared by bus, timer and converter core.
`default_nettype none
package adc_slot_pkg;
    // ==========================================================
    // Register map (byte addresses, one word each)
    localparam logic [7:0] MOTOR_FIVE_OFS = 8'h00;
    localparam logic [7:0] TIMER_0_3_OFS = 8'h04;
    localparam logic [7:0] TIMER_4_7_OFS = 8'h08;
    localparam logic [7:0] TIMER_8_11_OFS = 8'h0c;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h10;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h14;
    localparam logic [7:0] SEQ_STATUS_OFS = 8'h18;
    // ==========================================================
    // Field layout and reset values
    localparam logic [31:0] TIMER_WORD_MASK = 32'h9f9f9f9f;
    localparam logic [31:0] MOTOR_WORD_RESET = 32'h00000000;
    localparam logic [31:0] TIMER_WORD_RESET = 32'h00000000;
    localparam int SLOT_ENABLE_BIT = 7;
    localparam int PHASE_TAG_LSB = 5;
    localparam int TIMER_WORDS = 3;
    localparam logic [3:0] LAST_SLOT = 4'hb;
    localparam logic [4:0] UNIT_A_MAX_CHANNEL = 5'h0e;
    localparam logic [4:0] UNIT_B_MAX_CHANNEL = 5'h10;
    // Interrupt status bits
    localparam int IRQ_BITS = 2;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_OVERRUN_BIT = 1;
    localparam logic [IRQ_BITS-1:0] IRQ_RESET = 2'h0;
    // ==========================================================
    // Phase tag codes for the vector engine
    typedef enum logic [1:0] {
        PHASE_NONE = 2'b00,
        PHASE_U = 2'b01,
        PHASE_V = 2'b10,
        PHASE_W = 2'b11
    } phase_tag_e;
    // Sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_SCAN = 2'b01,
        SEQ_START = 2'b10,
        SEQ_WAIT = 2'b11
    } seq_state_e;
    // One conversion request toward the converter core
    typedef struct packed {
        logic start;
        logic [4:0] channel;
        logic [3:0] result_slot;
    } conv_req_s;
endpackage : adc_slot_pkg
`default_nettype wire

// [testbench/conv_partner.sv]
// Behavioural timer channel five and converter core for the slot bench.
// Assumes the bench commands trigger pulses and the conversion latency.
`default_nettype none
module conv_partner
    import adc_slot_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic fire_i,
    input wire logic [3:0] delay_i,
    input wire conv_req_s req_i,
    output logic trigger_o = 1'b0,
    output logic done_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy = 1'b0;
    logic [3:0] count = 4'h0;
    // ==========================================================
    // Timer pulse and converter latency
    // Done only ever follows a start, as the real core behaves
    always @(posedge clk_i)
    begin
        trigger_o <= fire_i & nrst_i;
        done_o <= 1'b0;
        if (!nrst_i)
            busy <= 1'b0;
        else if (req_i.start === 1'b1)
        begin
            busy <= 1'b1;
            count <= delay_i;
        end
        else if (busy && count == 4'h0)
        begin
            busy <= 1'b0;
            done_o <= 1'b1;
        end
        else if (busy)
            count <= count - 4'h1;
    end
endmodule : conv_partner
`default_nettype wire

// [testbench/adc_slot_ctrl_tb.sv]
// Self-checking bench for the converter slot block and its partner.
// Assumes one 100 MHz clock; the bus slave inserts no wait states.
`default_nettype none
module adc_slot_ctrl_tb
    import adc_slot_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic fire = 1'b0;
    logic [3:0] delay = 4'h0;
    logic [31:0] hrdata, motor, rd, w;
    logic hready, hresp, trig, done, irq;
    logic [7:0] addr, b;
    conv_req_s req;
    logic [8:0] seen[$];
    logic [31:0] tw[3];
    int seed = 41;
    int err_count = 0;
    int n_checks = 0;
    int n, k;
    adc_slot_ctrl #(.UNIT_B(1'b0)) dut (
        .CLK_I(clk), .NRST_I(nrst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
        .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(hresp),
        .TIMER5_TRIGGER_PULSE_I(trig), .CONV_DONE_I(done),
        .CONV_REQ_O(req), .MOTOR_TRIGGER_PROGRAM_FIVE_O(motor),
        .TIMER_CONVERSION_DONE_IRQ_O(irq));
    conv_partner partner (.clk_i(clk), .nrst_i(nrst), .fire_i(fire),
        .delay_i(delay), .req_i(req), .trigger_o(trig), .done_o(done));
    // ==========================================================
    // Clock, start log and watchdog
    initial
        forever #5 clk = ~clk;
    // Start stands one cycle, so the falling edge sees it once
    always @(negedge clk)
        if (req.start === 1'b1)
            seen.push_back({req.result_slot, req.channel});
    initial
    begin
        repeat (60000) @(posedge clk);
        $display("mismatch watchdog expected finish seen hang");
        err_count++;
        finish_test();
    end
    // ==========================================================
    // Shared tasks
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask : check
    // Values just before an edge equal those at the falling edge
    task automatic wait_rdy(output logic [31:0] data);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 100 && r !== 1'b1; i++)
        begin
            @(negedge clk);
            r = hready;
            data = hrdata;
            @(posedge clk);
        end
        if (r !== 1'b1)
        begin
            $display("mismatch hready expected 1 seen %b", r);
            err_count++;
            finish_test();
        end
    endtask : wait_rdy
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] data);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_rdy(data);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(data);
    endtask : bus
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    function automatic logic [7:0] slot_byte(input int m);
        return tw[m / 4][(m % 4) * 8 +: 8];
    endfunction : slot_byte
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        bus(1'b1, 8'h1c, 32'h12345678, rd);
        for (int a = 0; a < 8; a++)
        begin
            bus(1'b0, 8'(a * 4), 32'h0, rd);
            check("reset or unmapped", 32'h0, rd);
        end
        for (int p = 0; p < 4; p++)
        begin
            w = $random(seed);
            w[6:5] = p[1:0];
            bus(1'b1, MOTOR_FIVE_OFS, w, rd);
            bus(1'b0, MOTOR_FIVE_OFS, 32'h0, rd);
            check("motor word", w, rd);
            check("motor output", w, motor);
        end
        // All-ones first, so the read-only zero bits are exercised
        for (int j = 0; j < 6; j++)
        begin
            w = (j < 3) ? 32'hffffffff : $random(seed);
            addr = TIMER_0_3_OFS + 8'(4 * (j % 3));
            bus(1'b1, addr, w, rd);
            bus(1'b0, addr, 32'h0, rd);
            check("timer word", w & 32'h9f9f9f9f, rd);
        end
        // Runs: all slots, last slot only, masked, random
        for (int r = 0; r < 4; r++)
        begin
            for (int m = 0; m < 12; m++)
            begin
                b[7] = r == 0 || (r == 1 && m == 11)
                    || (r > 1 && ($random(seed) & 1) != 0);
                b[6:0] = 7'(($random(seed) & 32'hff) % 15);
                tw[m / 4][(m % 4) * 8 +: 8] = b;
            end
            for (int i = 0; i < 3; i++)
                bus(1'b1, TIMER_0_3_OFS + 8'(4 * i), tw[i], rd);
            bus(1'b1, IRQ_MASK_OFS, {31'h0, r != 2}, rd);
            delay <= 4'($random(seed));
            seen.delete();
            fire <= 1'b1;
            @(posedge clk);
            fire <= 1'b0;
            repeat (4) @(posedge clk);
            fire <= (r == 0);
            @(posedge clk);
            fire <= 1'b0;
            rd = 32'h1;
            for (n = 0; n < 400 && rd[1:0] !== 2'h0; n++)
                bus(1'b0, SEQ_STATUS_OFS, 32'h0, rd);
            check("sequence idle", 32'h0, rd[1:0]);
            if (rd[1:0] !== 2'h0)
                finish_test();
            @(posedge clk);
            k = 0;
            for (int m = 0; m < 12; m++)
            begin
                b = slot_byte(m);
                if (b[7])
                begin
                    check("slot start", {m[3:0], b[4:0]},
                        k < seen.size() ? seen[k] : 9'h1ff);
                    k++;
                end
            end
            check("start count", k, seen.size());
            check("irq level", r != 2, irq);
            bus(1'b0, IRQ_STATUS_OFS, 32'h0, rd);
            check("irq status", (r == 0) ? 32'h3 : 32'h1, rd);
            bus(1'b0, IRQ_STATUS_OFS, 32'h0, rd);
            check("status cleared", 32'h0, rd);
            check("irq cleared", 32'h0, irq);
        end
        check("bus response", 32'h0, hresp);
        finish_test();
    end
endmodule : adc_slot_ctrl_tb
`default_nettype wire
